// *** verilog/can_isp_defs.svh ***
`ifndef CAN_ISP_DEFS_SVH
`define CAN_ISP_DEFS_SVH

// Register byte addresses on the APB slave.
`define OFF_PORT_ONE_COND 12'h000
`define OFF_PORT_THREE_COND 12'h004
`define OFF_PORT_FOUR_COND 12'h008
`define OFF_BAUD_SOURCE 12'h00c
`define OFF_BIT_TIMING_A 12'h010
`define OFF_BIT_TIMING_B 12'h014
`define OFF_BIT_TIMING_C 12'h018
`define OFF_NODE_NUMBER 12'h01c
`define OFF_ID_BASE 12'h020
`define OFF_STATUS 12'h024
`define OFF_CONTROL 12'h028
`define OFF_VERSION 12'h02c

// Reset values of the configuration bytes.
`define RST_PORT_ONE_COND 8'hfe
`define RST_PORT_THREE_COND 8'hff
`define RST_PORT_FOUR_COND 8'hff
`define RST_BAUD_SOURCE 8'hff
`define RST_BIT_TIMING 8'hff
`define RST_NODE_NUMBER 8'hff
`define RST_ID_BASE 7'h00

// Special byte values.
`define BYTE_ALL_ONES 8'hff
`define SESSION_OPEN_BYTE 8'h01
`define SESSION_CLOSED_BYTE 8'h00
`define LOADER_VERSION 8'h01

// Low nibbles of the command identifiers.
`define NIB_SESSION_SELECT 4'h0
`define NIB_PROGRAM_START 4'h1
`define NIB_PROGRAM_PAYLOAD 4'h2
`define NIB_MEMORY_READOUT 4'h3
`define NIB_CONFIG_WRITE 4'h4
`define NIB_CONFIG_READ 4'h5
`define NIB_FAULT_REPORT 4'h6

// Frame lengths.
`define DLC_SELECT_REQ 4'h1
`define DLC_SELECT_ANS 4'h2

// Status and control bit positions.
`define ST_LOADER_MODE 0
`define ST_SESSION_OPEN 1
`define ST_AUTOBAUD 2
`define ST_ACK_ENABLE 3
`define ST_HW_COND 4
`define CTL_RESTART 0

`endif

// *** verilog/can_isp_pkg.sv ***
package can_isp_pkg;

  // One standard CAN data frame as seen by this block.
  typedef struct packed {
    logic ide;
    logic rtr;
    logic [10:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } can_frame_t;

  // A command passed on to the command handlers.
  typedef struct packed {
    logic [3:0] code;
    logic [3:0] dlc;
    logic [63:0] data;
  } isp_cmd_t;

  // Top-level sequencing states.
  typedef enum logic [2:0] {
    st_strap = 3'b000,
    st_app = 3'b001,
    st_init = 3'b010,
    st_autobaud = 3'b011,
    st_run = 3'b100
  } boot_state_t;

endpackage : can_isp_pkg

// *** verilog/can_isp_session_front_end.sv ***
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "can_isp_defs.svh"

module can_isp_session_front_end
  import can_isp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port pins and fuse.
  input wire logic [7:0] port_one_pins,
  input wire logic [7:0] port_three_pins,
  input wire logic [1:0] port_four_pins,
  input wire logic boot_jump_fuse,
  output logic loader_mode,
  // CAN controller set-up.
  output logic autobaud_run,
  input wire logic autobaud_found,
  output logic ack_enable,
  output logic timing_load,
  output logic [7:0] bit_timing_byte_a,
  output logic [7:0] bit_timing_byte_b,
  output logic [7:0] bit_timing_byte_c,
  // Received frames.
  input wire logic rx_valid,
  input wire can_frame_t rx_frame,
  output logic rx_ready,
  // Transmitted answers.
  output logic tx_valid,
  output can_frame_t tx_frame,
  input wire logic tx_ready,
  // Commands for the handlers behind this block.
  output logic cmd_valid,
  output isp_cmd_t cmd,
  // Configuration writes from loader commands.
  input wire logic cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  output logic session_open
);

  // Configuration bytes held by the block.
  logic [7:0] port_one_entry_condition;
  logic [7:0] port_three_entry_condition;
  logic [7:0] port_four_entry_condition;
  logic [7:0] baud_source_select_byte;
  logic [7:0] local_node_number;
  logic [6:0] identifier_base_byte;
  // Next values of the configuration bytes.
  logic [7:0] next_p1c, next_p3c, next_p4c, next_baud;
  logic [7:0] next_bta, next_btb, next_btc, next_node;
  logic [6:0] next_base;
  // A software request to restart the loader.
  logic restart_req;
  // Sequencing state and its next value.
  boot_state_t state, next_state;
  logic next_loader_mode, next_autobaud_run, next_ack_enable;
  logic next_timing_load;
  // Live evaluation of the entry condition.
  logic hw_cond;
  // Frame handling next values.
  logic next_session_open, next_tx_valid, next_cmd_valid;
  can_frame_t next_tx_frame;
  isp_cmd_t next_cmd;
  // Read data and error captured in the setup phase.
  logic [31:0] next_prdata;
  logic next_pslverr;
  // Access-phase write strobe.
  logic apb_wr;
  // Frame decode helpers.
  logic frame_take, frame_ours;
  logic [3:0] frame_nib;
  // Stored bit-timing bytes, shown directly on the outputs.
  logic [7:0] bta_q, btb_q, btc_q;

  // The slave never inserts wait states.
  assign pready = psel & penable;
  assign apb_wr = psel & penable & pwrite;
  assign bit_timing_byte_a = bta_q;
  assign bit_timing_byte_b = btb_q;
  assign bit_timing_byte_c = btc_q;

  // Entry condition: the first configured port in priority order decides.
  always_comb begin
    if (port_one_entry_condition != `BYTE_ALL_ONES) begin
      hw_cond = (port_one_pins == port_one_entry_condition);
    end else if (port_three_entry_condition != `BYTE_ALL_ONES) begin
      hw_cond = (port_three_pins == port_three_entry_condition);
    end else if (port_four_entry_condition != `BYTE_ALL_ONES) begin
      // Only the two low bits of the fourth port take part.
      hw_cond = (port_four_pins == port_four_entry_condition[1:0]);
    end else begin
      hw_cond = 1'b0;
    end
  end

  // Configuration writes: APB wins over a loader write in the same cycle.
  always_comb begin
    next_p1c = port_one_entry_condition;
    next_p3c = port_three_entry_condition;
    next_p4c = port_four_entry_condition;
    next_baud = baud_source_select_byte;
    next_bta = bta_q;
    next_btb = btb_q;
    next_btc = btc_q;
    next_node = local_node_number;
    next_base = identifier_base_byte;
    if (apb_wr) begin
      if (paddr == `OFF_PORT_ONE_COND) begin
        next_p1c = pwdata[7:0];
      end else if (paddr == `OFF_PORT_THREE_COND) begin
        next_p3c = pwdata[7:0];
      end else if (paddr == `OFF_PORT_FOUR_COND) begin
        next_p4c = pwdata[7:0];
      end else if (paddr == `OFF_BAUD_SOURCE) begin
        next_baud = pwdata[7:0];
      end else if (paddr == `OFF_BIT_TIMING_A) begin
        next_bta = pwdata[7:0];
      end else if (paddr == `OFF_BIT_TIMING_B) begin
        next_btb = pwdata[7:0];
      end else if (paddr == `OFF_BIT_TIMING_C) begin
        next_btc = pwdata[7:0];
      end else if (paddr == `OFF_NODE_NUMBER) begin
        next_node = pwdata[7:0];
      end else if (paddr == `OFF_ID_BASE) begin
        // Only seven bits are stored, so the base cannot pass 7Fh.
        next_base = pwdata[6:0];
      end
    end else if (cfg_wr) begin
      if (cfg_addr == `OFF_PORT_ONE_COND) begin
        next_p1c = cfg_data;
      end else if (cfg_addr == `OFF_PORT_THREE_COND) begin
        next_p3c = cfg_data;
      end else if (cfg_addr == `OFF_PORT_FOUR_COND) begin
        next_p4c = cfg_data;
      end else if (cfg_addr == `OFF_BAUD_SOURCE) begin
        next_baud = cfg_data;
      end else if (cfg_addr == `OFF_BIT_TIMING_A) begin
        next_bta = cfg_data;
      end else if (cfg_addr == `OFF_BIT_TIMING_B) begin
        next_btb = cfg_data;
      end else if (cfg_addr == `OFF_BIT_TIMING_C) begin
        next_btc = cfg_data;
      end else if (cfg_addr == `OFF_NODE_NUMBER) begin
        next_node = cfg_data;
      end else if (cfg_addr == `OFF_ID_BASE) begin
        next_base = cfg_data[6:0];
      end
    end
  end

  // Register the configuration bytes.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      port_one_entry_condition <= `RST_PORT_ONE_COND;
      port_three_entry_condition <= `RST_PORT_THREE_COND;
      port_four_entry_condition <= `RST_PORT_FOUR_COND;
      baud_source_select_byte <= `RST_BAUD_SOURCE;
      bta_q <= `RST_BIT_TIMING;
      btb_q <= `RST_BIT_TIMING;
      btc_q <= `RST_BIT_TIMING;
      local_node_number <= `RST_NODE_NUMBER;
      identifier_base_byte <= `RST_ID_BASE;
    end else begin
      port_one_entry_condition <= next_p1c;
      port_three_entry_condition <= next_p3c;
      port_four_entry_condition <= next_p4c;
      baud_source_select_byte <= next_baud;
      bta_q <= next_bta;
      btb_q <= next_btb;
      btc_q <= next_btc;
      local_node_number <= next_node;
      identifier_base_byte <= next_base;
    end
  end

  // A write of the restart bit asks for a fresh loader start.
  assign restart_req = apb_wr & (paddr == `OFF_CONTROL) & pwdata[`CTL_RESTART];

  // Boot sequencing: catch the pins once after reset, then set up the link.
  always_comb begin
    next_state = state;
    next_loader_mode = loader_mode;
    next_autobaud_run = 1'b0;
    next_ack_enable = ack_enable;
    next_timing_load = 1'b0;
    case (state)
      st_strap: begin
        // The pins are sampled at the first edge after reset release.
        if (hw_cond && !boot_jump_fuse) begin
          next_state = st_init;
          next_loader_mode = 1'b1;
        end else begin
          next_state = st_app;
        end
      end
      st_app: begin
        // A restart is only honoured while boot_jump_fuse is low.
        if (restart_req && !boot_jump_fuse) begin
          next_state = st_init;
          next_loader_mode = 1'b1;
        end
      end
      st_init: begin
        if (baud_source_select_byte == `BYTE_ALL_ONES) begin
          next_state = st_autobaud;
          next_autobaud_run = 1'b1;
          next_ack_enable = 1'b0;
        end else begin
          next_state = st_run;
          next_timing_load = 1'b1;
          next_ack_enable = 1'b1;
        end
      end
      st_autobaud: begin
        // Acknowledge stays off until a timing has been found.
        if (autobaud_found) begin
          next_state = st_run;
          next_ack_enable = 1'b1;
        end else begin
          next_autobaud_run = 1'b1;
        end
      end
      st_run: begin
        next_state = st_run;
      end
      default: begin
        next_state = st_strap;
      end
    endcase
  end

  // Register the sequencing state.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= st_strap;
      loader_mode <= 1'b0;
      autobaud_run <= 1'b0;
      ack_enable <= 1'b0;
      timing_load <= 1'b0;
    end else begin
      state <= next_state;
      loader_mode <= next_loader_mode;
      autobaud_run <= next_autobaud_run;
      ack_enable <= next_ack_enable;
      timing_load <= next_timing_load;
    end
  end

  // Frames are taken only in the run state while no answer is pending.
  assign rx_ready = (state == st_run) & ~tx_valid;
  assign frame_take = rx_valid & rx_ready;
  // Only standard data frames whose upper id bits match the base count.
  assign frame_ours = ~rx_frame.ide & ~rx_frame.rtr
                    & (rx_frame.id[10:4] == identifier_base_byte);
  assign frame_nib = rx_frame.id[3:0];

  // Session handling, answers and command dispatch.
  always_comb begin
    next_session_open = session_open;
    next_tx_valid = tx_valid & ~tx_ready;
    next_tx_frame = tx_frame;
    next_cmd_valid = 1'b0;
    next_cmd = cmd;
    if (frame_take && frame_ours) begin
      if (frame_nib == `NIB_SESSION_SELECT) begin
        // A one-byte select naming this node or every node is accepted.
        if ((rx_frame.dlc == `DLC_SELECT_REQ)
            && ((rx_frame.data[63:56] == `BYTE_ALL_ONES)
            || (rx_frame.data[63:56] == local_node_number))) begin
          next_session_open = ~session_open;
          next_tx_valid = 1'b1;
          next_tx_frame.ide = 1'b0;
          next_tx_frame.rtr = 1'b0;
          next_tx_frame.id = {identifier_base_byte, `NIB_SESSION_SELECT};
          next_tx_frame.dlc = `DLC_SELECT_ANS;
          next_tx_frame.data = {`LOADER_VERSION,
                                ~session_open ? `SESSION_OPEN_BYTE
                                              : `SESSION_CLOSED_BYTE,
                                48'h0};
        end
      end else if (session_open && (frame_nib >= `NIB_PROGRAM_START)
                   && (frame_nib <= `NIB_CONFIG_READ)) begin
        // Fault identifiers and unknown nibbles fall through unused.
        next_cmd_valid = 1'b1;
        next_cmd.code = frame_nib;
        next_cmd.dlc = rx_frame.dlc;
        next_cmd.data = rx_frame.data;
      end
    end
    // Leaving the run state always ends the session.
    if (state != st_run) begin
      next_session_open = 1'b0;
    end
  end

  // Register session, answer and command outputs.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      session_open <= 1'b0;
      tx_valid <= 1'b0;
      tx_frame <= '0;
      cmd_valid <= 1'b0;
      cmd <= '0;
    end else begin
      session_open <= next_session_open;
      tx_valid <= next_tx_valid;
      tx_frame <= next_tx_frame;
      cmd_valid <= next_cmd_valid;
      cmd <= next_cmd;
    end
  end

  // Read data is captured in the setup phase and shown in the access phase.
  always_comb begin
    next_prdata = 32'h0;
    next_pslverr = 1'b0;
    if (paddr == `OFF_PORT_ONE_COND) begin
      next_prdata = {24'h0, port_one_entry_condition};
    end else if (paddr == `OFF_PORT_THREE_COND) begin
      next_prdata = {24'h0, port_three_entry_condition};
    end else if (paddr == `OFF_PORT_FOUR_COND) begin
      next_prdata = {24'h0, port_four_entry_condition};
    end else if (paddr == `OFF_BAUD_SOURCE) begin
      next_prdata = {24'h0, baud_source_select_byte};
    end else if (paddr == `OFF_BIT_TIMING_A) begin
      next_prdata = {24'h0, bta_q};
    end else if (paddr == `OFF_BIT_TIMING_B) begin
      next_prdata = {24'h0, btb_q};
    end else if (paddr == `OFF_BIT_TIMING_C) begin
      next_prdata = {24'h0, btc_q};
    end else if (paddr == `OFF_NODE_NUMBER) begin
      next_prdata = {24'h0, local_node_number};
    end else if (paddr == `OFF_ID_BASE) begin
      next_prdata = {25'h0, identifier_base_byte};
    end else if (paddr == `OFF_STATUS) begin
      next_prdata = {27'h0, hw_cond, ack_enable, autobaud_run,
                     session_open, loader_mode};
    end else if (paddr == `OFF_CONTROL) begin
      next_prdata = 32'h0;
    end else if (paddr == `OFF_VERSION) begin
      next_prdata = {24'h0, `LOADER_VERSION};
    end else begin
      // Unmapped addresses answer with an error and zero data.
      next_pslverr = 1'b1;
    end
  end

  // Register the read answer at the setup edge.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule : can_isp_session_front_end

// *** testbench/can_isp_chk.sv ***
`timescale 1ns/1ps
// Watches the session front end from its ports only.
module can_isp_chk
  import can_isp_pkg::*;
(
  input logic clk_sys,
  input logic reset,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic autobaud_run,
  input logic ack_enable,
  input logic timing_load,
  input logic rx_valid,
  input can_frame_t rx_frame,
  input logic rx_ready,
  input logic tx_valid,
  input can_frame_t tx_frame,
  input logic tx_ready,
  input logic cmd_valid,
  input isp_cmd_t cmd,
  input logic session_open
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // A frame is taken at this edge.
  logic take;
  assign take = rx_valid && rx_ready;
  a_pready_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready missing in access phase");
  a_answer_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("answer dropped or changed before tx_ready");
  a_answer_form: assert property ($rose(tx_valid) |-> tx_frame.dlc == 4'h2
    && tx_frame.id[3:0] == 4'h0 && tx_frame.data[63:56] == 8'h01 && !tx_frame.ide
    && tx_frame.data[55:48] == {7'h00, session_open}) else $error("bad answer");
  a_select_toggles: assert property ($changed(session_open) |-> $rose(tx_valid))
    else $error("session changed without an answer");
  a_ext_ignored: assert property (take && (rx_frame.ide || rx_frame.rtr) |=>
    !tx_valid && !cmd_valid) else $error("extended or remote frame acted on");
  a_fault_ignored: assert property (take && rx_frame.id[3:0] == 4'h6 |=>
    !tx_valid && !cmd_valid) else $error("fault identifier accepted");
  a_cmd_needs_session: assert property (cmd_valid |-> $past(session_open))
    else $error("command passed on without a session");
  a_cmd_code_range: assert property (cmd_valid |-> cmd.code inside {[4'h1:4'h5]})
    else $error("command code outside one to five");
  a_autobaud_no_ack: assert property (autobaud_run |-> !ack_enable)
    else $error("acknowledge enabled during baud detection");
  a_timing_ack: assert property (timing_load |-> ack_enable && !autobaud_run
    ##1 !timing_load) else $error("timing load not a single pulse with ack");
  c_answer: cover property ($rose(tx_valid));
  c_cmd: cover property (cmd_valid);
  c_timing: cover property (timing_load);
endmodule : can_isp_chk

bind can_isp_session_front_end can_isp_chk u_chk (
  .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
  .pready(pready), .autobaud_run(autobaud_run), .ack_enable(ack_enable),
  .timing_load(timing_load), .rx_valid(rx_valid), .rx_frame(rx_frame),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame),
  .tx_ready(tx_ready), .cmd_valid(cmd_valid), .cmd(cmd),
  .session_open(session_open)
);

// *** testbench/host_station.sv ***
`timescale 1ns/1ps
// Programming station on the far side of the CAN controller.
module host_station
  import can_isp_pkg::*;
(
  input logic clk_sys,
  input logic reset,
  input logic slow,
  output logic rx_valid,
  output can_frame_t rx_frame,
  input logic rx_ready,
  input logic tx_valid,
  input can_frame_t tx_frame,
  output logic tx_ready
);
  can_frame_t req; // Frame on offer.
  can_frame_t noise; // Changes each cycle so idle lines never look valid.
  logic [1:0] wait_cnt; // Stall counter for slow answers.
  assign rx_frame = rx_valid ? req : noise;
  initial begin
    rx_valid = 1'b0;
    req = '0;
  end
  // Idle pattern and answer acceptance, slow mode waits four cycles.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      noise <= '0;
      wait_cnt <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      noise <= ~noise;
      wait_cnt <= tx_valid ? wait_cnt + 2'h1 : 2'h0;
      tx_ready <= tx_valid && !tx_ready && (!slow || wait_cnt == 2'h3);
    end
  end
  // Offers one frame with the given ide and rtr bits, held until the device takes it.
  task automatic send(input logic [10:0] id, input logic [3:0] dlc,
                      input logic [63:0] data, input logic ide,
                      input logic rtr, output bit ok);
    int n;
    ok = 0;
    // Change the offer only just after a rising edge.
    @(posedge clk_sys);
    req <= '{ide, rtr, id, dlc, data};
    rx_valid <= 1'b1;
    for (n = 0; n < 200 && !ok; n++) begin
      @(negedge clk_sys);
      ok = (rx_ready === 1'b1);
      @(posedge clk_sys);
    end
    rx_valid <= 1'b0;
  endtask : send
endmodule : host_station

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`include "can_isp_defs.svh"
// Self-checking bench for the session front end.
module testbench
  import can_isp_pkg::*;
;
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, fuse, slow;
  logic [11:0] paddr, cfg_addr;
  logic [31:0] pwdata, prdata, seed, r;
  logic [7:0] p1, p3, bta, btb, btc, cfg_data;
  logic [1:0] p4;
  logic loader_mode, autobaud_run, found, ack_enable, timing_load, cfg_wr;
  logic rx_valid, rx_ready, tx_valid, tx_ready, cmd_valid, session_open;
  can_frame_t rx_frame, tx_frame;
  isp_cmd_t cmd;
  logic [32:0] got;
  logic [33:0] a;
  logic [63:0] d;
  logic [3:0] dl;
  int err_count, check_count;
  logic [33:0] apbq[$]; // Bus results: read flag, error, data.
  logic [32:0] txq[$]; // Expected answer frames.
  logic [71:0] cmdq[$]; // Expected commands.
  logic [11:0] ra [10] = '{`OFF_PORT_ONE_COND, `OFF_PORT_THREE_COND,
    `OFF_PORT_FOUR_COND, `OFF_BAUD_SOURCE, `OFF_BIT_TIMING_A,
    `OFF_BIT_TIMING_B, `OFF_BIT_TIMING_C, `OFF_NODE_NUMBER, `OFF_ID_BASE,
    `OFF_VERSION};
  logic [7:0] rv [10] = '{8'hfe, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'h00, 8'h01};
  can_isp_session_front_end u_dut (.clk_sys(clk_sys), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_one_pins(p1), .port_three_pins(p3), .port_four_pins(p4),
    .boot_jump_fuse(fuse), .loader_mode(loader_mode),
    .autobaud_run(autobaud_run), .autobaud_found(found),
    .ack_enable(ack_enable), .timing_load(timing_load),
    .bit_timing_byte_a(bta), .bit_timing_byte_b(btb),
    .bit_timing_byte_c(btc), .rx_valid(rx_valid), .rx_frame(rx_frame),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame),
    .tx_ready(tx_ready), .cmd_valid(cmd_valid), .cmd(cmd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .session_open(session_open));
  host_station u_host (.clk_sys(clk_sys), .reset(reset), .slow(slow),
    .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_ready(tx_ready));
  // Clock of 50 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Compares one value and counts the result.
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // One APB transfer; the expected result is noted for the monitor.
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] wd, input logic [32:0] exp);
    int n;
    apbq.push_back({!wr, exp});
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 20) err_count++;
    if (n == 20) conclude();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Waits, bounded, until a flag reads high.
  task automatic wait_high(ref logic s);
    int n;
    for (n = 0; n < 100 && s !== 1'b1; n++) @(negedge clk_sys);
    check(s, 1'b1);
    if (n == 100) conclude();
  endtask : wait_high
  // Offers a frame, then lets any answer drain.
  task automatic frame(input logic [10:0] id, input logic [3:0] dlc,
                       input logic [63:0] dt, input logic ide, input logic rtr);
    bit ok;
    int n;
    u_host.send(id, dlc, dt, ide, rtr, ok);
    if (!ok) err_count++;
    if (!ok) conclude();
    for (n = 0; n < 3 || (tx_valid !== 1'b0 && n < 40); n++) @(negedge clk_sys);
    if (tx_valid !== 1'b0) begin
      err_count++;
      conclude();
    end
  endtask : frame
  // Session select; an accepted one is answered with the new state.
  task automatic sel(input logic [6:0] b, input logic [7:0] node,
                     input logic acc, input logic now_open);
    r = $random(seed);
    slow <= r[0];
    if (acc) txq.push_back({2'b00, b, 4'h0, 4'h2, 8'h01, 7'h00, now_open});
    frame({b, 4'h0}, 4'h1, {node, 56'h0}, 1'b0, 1'b0);
    check(session_open, now_open);
  endtask : sel
  // Reset with chosen pins and fuse.
  task automatic do_reset(input logic [7:0] pins, input logic fz);
    reset <= 1'b1;
    p1 <= pins;
    fuse <= fz;
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask : do_reset
  // Monitor: takes the oldest note whenever a result appears.
  always @(posedge clk_sys) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      got = {tx_frame.ide, tx_frame.rtr, tx_frame.id, tx_frame.dlc,
             tx_frame.data[63:48]};
      check(got, txq.size() > 0 ? txq.pop_front() : ~got);
    end
    if (cmd_valid === 1'b1)
      check(cmd, cmdq.size() > 0 ? cmdq.pop_front() : ~cmd);
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      a = apbq.pop_front();
      check(pslverr, a[32]);
      if (a[33]) check(prdata, a[31:0]);
    end
  end
  // Stops a hung run.
  initial begin
    repeat (50000) @(posedge clk_sys);
    err_count++;
    conclude();
  end
  // Main sequence.
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata, cfg_wr} = '0;
    {cfg_addr, cfg_data, found, slow, p3, p4} = '0;
    reset = 1'b1;
    p1 = 8'hfe;
    fuse = 1'b0;
    seed = 32'hb52c;
    err_count = 0;
    check_count = 0;
    do_reset(8'hfe, 1'b0);
    check({loader_mode, autobaud_run, ack_enable}, 3'b110);
    for (int i = 0; i < 10; i++) apb(1'b0, ra[i], 0, {1'b0, 24'h0, rv[i]});
    apb(1'b0, 12'h030, 0, {1'b1, 32'h0});
    @(posedge clk_sys) found <= 1'b1;
    @(posedge clk_sys) found <= 1'b0;
    wait_high(ack_enable);
    apb(1'b0, `OFF_STATUS, 0, {1'b0, 32'h19});
    $display("test 1 done");
    for (int i = 1; i < 7; i++) frame({7'h00, i[3:0]}, 4'h1, 0, 1'b0, 1'b0);
    frame(11'h000, 4'h1, {8'hff, 56'h0}, 1'b1, 1'b0);
    frame(11'h000, 4'h1, {8'hff, 56'h0}, 1'b0, 1'b1);
    frame(11'h000, 4'h2, {8'hff, 56'h0}, 1'b0, 1'b0);
    sel(7'h01, 8'hff, 1'b0, 1'b0);
    sel(7'h00, 8'h05, 1'b0, 1'b0);
    $display("test 2 done");
    sel(7'h00, 8'hff, 1'b1, 1'b1);
    for (int c = 1; c < 6; c++) begin
      r = $random(seed);
      dl = (c == 5) ? 4'h8 : 4'(r % 9);
      d = {$random(seed), $random(seed)};
      cmdq.push_back({c[3:0], dl, d});
      frame({7'h00, c[3:0]}, dl, d, 1'b0, 1'b0);
    end
    sel(7'h00, 8'hff, 1'b1, 1'b0);
    $display("test 3 done");
    apb(1'b1, `OFF_NODE_NUMBER, 32'h23, 0);
    apb(1'b1, `OFF_ID_BASE, 32'hff, 0);
    apb(1'b0, `OFF_ID_BASE, 0, {1'b0, 32'h7f});
    sel(7'h7f, 8'h22, 1'b0, 1'b0);
    sel(7'h00, 8'h23, 1'b0, 1'b0);
    sel(7'h7f, 8'h23, 1'b1, 1'b1);
    sel(7'h7f, 8'hff, 1'b1, 1'b0);
    @(posedge clk_sys) {cfg_wr, cfg_addr, cfg_data} <= {1'b1, `OFF_BIT_TIMING_B, 8'h3c};
    @(posedge clk_sys) cfg_wr <= 1'b0;
    apb(1'b0, `OFF_BIT_TIMING_B, 0, {1'b0, 32'h3c});
    check(btb, 8'h3c);
    $display("test 4 done");
    do_reset(8'h00, 1'b1);
    check({loader_mode, rx_ready}, 2'b00);
    apb(1'b1, `OFF_BAUD_SOURCE, 32'h00, 0);
    apb(1'b1, `OFF_BIT_TIMING_A, 32'h11, 0);
    apb(1'b1, `OFF_BIT_TIMING_C, 32'h33, 0);
    apb(1'b1, `OFF_CONTROL, 32'h1, 0);
    repeat (5) @(posedge clk_sys);
    check(loader_mode, 1'b0);
    fuse <= 1'b0;
    apb(1'b1, `OFF_CONTROL, 32'h1, 0);
    wait_high(timing_load);
    check({bta, btc, ack_enable, autobaud_run}, {8'h11, 8'h33, 2'b10});
    check(loader_mode, 1'b1);
    $display("test 5 done");
    check(txq.size() + cmdq.size(), 0);
    conclude();
  end
endmodule : testbench
